/* File: rtl/ccbc_top.sv */
// capability bounds encoder and decoder with registered outputs
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ccbc_top
   import ccbc_pkg::*;
(
   input  wire logic                       mclk,
   input  wire logic                       srst,
   input  wire logic                       enc_req,
   input  wire ccbc_pkg::ccbc_enc_in_type  enc_in,
   output      logic                       enc_valid_r,
   output      ccbc_pkg::ccbc_enc_out_type enc_out_r,
   input  wire logic                       dec_req,
   input  wire ccbc_pkg::ccbc_dec_in_type  dec_in,
   output      logic                       dec_valid_r,
   output      ccbc_pkg::ccbc_dec_out_type dec_out_r
);
   import ccbc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // encoder signals
   logic [32:0]      base33;       // zero-extended base
   logic [32:0]      top33;        // zero-extended base plus length
   logic [4:0]       lzc;          // leading zeros of length[31:9]
   logic [4:0]       e_cand;       // candidate exponent
   logic [4:0]       e_next;       // candidate plus one
   logic [20:0]      sl_cand;      // slices at candidate
   logic [20:0]      sl_next;      // slices at next exponent
   logic [10:0]      diff_cand;    // rounded top minus base slice
   logic             bump;         // candidate overflowed
   logic [4:0]       e_fin;        // chosen exponent
   logic [9:0]       b_fin;        // chosen base slice
   logic [10:0]      t_fin;        // chosen rounded top slice
   logic [8:0]       mant_diff;    // truncated top minus base
   ccbc_enc_out_type enc_nxt;      // encoder result

   ////////////////////////////////////////////////////////////////////////////
   // decoder signals
   logic [4:0]       dec_e;        // decoded exponent
   logic [5:0]       dec_sh;       // exponent plus nine
   logic             implicit_length_msb;  // hidden ninth length bit
   logic             dec_rsv;      // reserved exponent code
   logic [32:0]      addr_sh;      // address shifted by exponent
   logic             a_hi;         // address slice below base field
   logic [8:0]       top9;         // rebuilt 9-bit top
   logic             t_hi;         // top field below base field
   logic [32:0]      upper;        // address bits above the region
   logic [32:0]      up_b;         // corrected upper bits for base
   logic [32:0]      up_t;         // corrected upper bits for top
   logic [32:0]      base_w;       // decoded base, 33 bits
   logic [32:0]      top_w;        // decoded top
   logic [33:0]      rep_lim;      // end of representable region
   logic             rep_ok;       // address inside region
   ccbc_dec_out_type dec_nxt;      // decoder result

   ////////////////////////////////////////////////////////////////////////////
   // slice helper: base slice and rounded top slice at one exponent
   function automatic logic [20:0] ccbc_slice(
      input logic [32:0] b33,
      input logic [32:0] t33,
      input logic [4:0]  e
   );
      logic [32:0] bs;
      logic [32:0] ts;
      logic [32:0] m;
      bs = b33 >> e;
      ts = t33 >> e;
      m  = (33'h000000001 << e) - 33'h000000001;
      // round up whenever truncated bits are nonzero
      return {bs[9:0], {1'b0, ts[9:0]} + {10'h000, |(t33 & m)}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // leading zero count of length[31:9]
   always_comb begin
      lzc = CLZ_TOP;                               // all zero: exponent 0
      for (int i = 0; i < 23; i++) begin
         // ascending scan so the highest set bit wins
         if (enc_in.length[LEN_LO + i]) begin
            lzc = 5'(22 - i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // encoder datapath
   always_comb begin
      base33    = {1'b0, enc_in.base};
      top33     = base33 + {1'b0, enc_in.length};
      e_cand    = CLZ_TOP - lzc;
      e_next    = e_cand + 5'h01;
      sl_cand   = ccbc_slice(base33, top33, e_cand);
      sl_next   = ccbc_slice(base33, top33, e_next);
      // modulo-1024 difference: the top slice may wrap below the base slice
      diff_cand = {1'b0, sl_cand[9:0] - sl_cand[20:11]};
      bump      = (diff_cand >= SLICE_SPAN);
      // overflow: retake both slices one exponent up
      if (bump) begin
         e_fin = e_next;
         b_fin = sl_next[20:11];
         t_fin = sl_next[10:0];
      end else begin
         e_fin = e_cand;
         b_fin = sl_cand[20:11];
         t_fin = sl_cand[10:0];
      end
      // worst case is e 23 bumped to 24, so 25..30 never appear
      mant_diff      = t_fin[8:0] - b_fin[8:0];
      enc_nxt.base_f = b_fin[8:0];
      enc_nxt.top_f  = t_fin[7:0];
      enc_nxt.len_f  = mant_diff[7:0];
      // small lengths are flagged by the special code
      if ((e_fin == 5'h00) && !mant_diff[8]) begin
         enc_nxt.exp_f = EXP_SPECIAL;
      end else begin
         enc_nxt.exp_f = e_fin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoder datapath, shared front end for both variants
   always_comb begin
      dec_rsv = (dec_in.fields.exp_f > EXP_MAX) &&
                (dec_in.fields.exp_f != EXP_SPECIAL);
      dec_e   = (dec_in.fields.exp_f == EXP_SPECIAL) ? 5'h00
                                                     : dec_in.fields.exp_f;
      implicit_length_msb = (dec_in.fields.exp_f != EXP_SPECIAL);
      dec_sh  = {1'b0, dec_e} + MANT_SH;
      addr_sh = {1'b0, dec_in.addr} >> dec_e;
      a_hi    = (addr_sh[8:0] < dec_in.fields.base_f);
      // top bit 8 recovered from base, implicit bit and wrap
      top9    = {dec_in.fields.base_f[8] ^ implicit_length_msb ^
                 (dec_in.fields.tl_f < dec_in.fields.base_f[7:0]),
                 dec_in.fields.tl_f};
      t_hi    = (top9 < dec_in.fields.base_f);
      upper   = {1'b0, dec_in.addr} >> dec_sh;
      up_b    = upper - {32'h00000000, a_hi};
      // top sits one region above base when its field is below the base field
      up_t    = upper - {32'h00000000, a_hi} + {32'h00000000, t_hi};
      base_w  = (up_b << dec_sh) |
                ({24'h000000, dec_in.fields.base_f} << dec_e);
      // both variants decode to the same bounds
      if (dec_in.fmt == CCBC_FMT_LEN) begin
         top_w = {1'b0, base_w[31:0]} +
                 ({24'h000000, implicit_length_msb, dec_in.fields.tl_f} << dec_e);
      end else begin
         top_w = (up_t << dec_sh) | ({24'h000000, top9} << dec_e);
      end
      // region is one 2^(e+9) span from base, never below it
      rep_lim = {1'b0, base_w[31:0]} + (34'h000000001 << dec_sh);
      rep_ok  = (dec_in.addr >= base_w[31:0]) &&
                ({2'b00, dec_in.addr} < rep_lim);
      dec_nxt.base   = base_w[31:0];
      dec_nxt.top    = top_w;
      dec_nxt.exp    = dec_e;
      dec_nxt.rsv    = dec_rsv;
      dec_nxt.rep_ok = rep_ok;
      dec_nxt.tag    = dec_in.tag && rep_ok && !dec_rsv;
   end

   ////////////////////////////////////////////////////////////////////////////
   // encoder output register; permission and type fields pass elsewhere
   always_ff @(posedge mclk) begin
      if (srst) begin
         enc_valid_r <= 1'b0;
         enc_out_r   <= ENC_OUT_RST;
      end else begin
         enc_valid_r <= enc_req;
         // hold the last result while idle
         if (enc_req) begin
            enc_out_r <= enc_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoder output register
   always_ff @(posedge mclk) begin
      if (srst) begin
         dec_valid_r <= 1'b0;
         dec_out_r   <= DEC_OUT_RST;
      end else begin
         dec_valid_r <= dec_req;
         // same field layout as the older format apart from bounds
         if (dec_req) begin
            dec_out_r <= dec_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on the encoder
   a_enc_latency: assert property (@(posedge mclk) disable iff (srst)
      enc_req |=> enc_valid_r)
      else $error("encoder result not one cycle after request");

   a_enc_no_rsv: assert property (@(posedge mclk) disable iff (srst)
      enc_valid_r |-> (enc_out_r.exp_f <= EXP_MAX) || (enc_out_r.exp_f == EXP_SPECIAL))
      else $error("encoder produced a reserved exponent");

   a_enc_norm: assert property (@(posedge mclk) disable iff (srst)
      enc_valid_r && (enc_out_r.exp_f != EXP_SPECIAL) && $past(enc_req) |->
         8'(enc_out_r.top_f - enc_out_r.base_f[7:0]) == enc_out_r.len_f)
      else $error("length field disagrees with top field");

   a_enc_exp_min: assert property (@(posedge mclk) disable iff (srst)
      enc_req |=> ((enc_out_r.exp_f == EXP_SPECIAL) ? 5'h00 : enc_out_r.exp_f)
                  >= $past(e_cand))
      else $error("encoded exponent below candidate");

   a_enc_bump: assert property (@(posedge mclk) disable iff (srst)
      enc_req && bump |=> enc_out_r.exp_f == $past(e_cand) + 5'h01)
      else $error("overflow did not raise the exponent by one");

   ////////////////////////////////////////////////////////////////////////////
   // checks on the decoder
   a_dec_rsv_flag: assert property (@(posedge mclk) disable iff (srst)
      dec_req && (dec_in.fields.exp_f > EXP_MAX) && (dec_in.fields.exp_f != EXP_SPECIAL)
         |=> dec_out_r.rsv && !dec_out_r.tag)
      else $error("reserved exponent not flagged");

   a_dec_order: assert property (@(posedge mclk) disable iff (srst)
      dec_valid_r && !dec_out_r.rsv |-> dec_out_r.top >= {1'b0, dec_out_r.base})
      else $error("decoded top below base");

   a_dec_base_mant: assert property (@(posedge mclk) disable iff (srst)
      dec_req ##1 !dec_out_r.rsv |->
         9'(dec_out_r.base >> dec_out_r.exp) == $past(dec_in.fields.base_f))
      else $error("base mantissa not placed at exponent");

   a_dec_rep_tag: assert property (@(posedge mclk) disable iff (srst)
      dec_req |=> dec_out_r.tag ==
         ($past(dec_in.tag) && !dec_out_r.rsv &&
          ($past(dec_in.addr) >= dec_out_r.base) &&
          ({2'b00, $past(dec_in.addr)} <
           {1'b0, dec_out_r.base} + (34'h000000001 << ({1'b0, dec_out_r.exp} + MANT_SH)))))
      else $error("tag not cleared outside representable region");

   a_dec_len_top: assert property (@(posedge mclk) disable iff (srst)
      dec_req && (dec_in.fmt == CCBC_FMT_LEN) |=> dec_out_r.top ==
         {1'b0, dec_out_r.base} +
         ({24'h000000, $past(implicit_length_msb), $past(dec_in.fields.tl_f)} << dec_out_r.exp))
      else $error("length variant top mismatch");

   a_dec_small: assert property (@(posedge mclk) disable iff (srst)
      dec_req && (dec_in.fields.exp_f == EXP_SPECIAL) |=> dec_out_r.exp == 5'h00)
      else $error("special code did not decode as exponent zero");

endmodule

/* File: common/ccbc_pkg.sv */
// shared constants and carriers for the capability bounds codec
package ccbc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // field widths
   localparam int ADDR_W  = 32;    // capability address width
   localparam int EXP_W   = 5;     // exponent field width
   localparam int MANT_W  = 9;     // mantissa width, base field width
   localparam int FLD_W   = 8;     // stored top or length field width
   localparam int SLICE_W = 10;    // encoder slice width
   localparam int LEN_LO  = 9;     // lowest length bit seen by the lzc

   ////////////////////////////////////////////////////////////////////////////
   // exponent codes and limits
   localparam logic [4:0]  EXP_SPECIAL = 5'h1F;   // exp zero, length below 256
   localparam logic [4:0]  EXP_MAX     = 5'h18;   // largest legal exponent
   localparam logic [4:0]  CLZ_TOP     = 5'h17;   // candidate exponent base
   localparam logic [5:0]  MANT_SH     = 6'h09;   // region shift over exponent
   localparam logic [10:0] SLICE_SPAN  = 11'h200; // slice overflow threshold
   localparam int          OUT_LAT     = 1;       // cycles from request to result

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef enum logic {
      CCBC_FMT_TOP = 1'b0,                         // stored field is top
      CCBC_FMT_LEN = 1'b1                          // stored field is length
   } ccbc_fmt_type;

   typedef struct packed {
      logic [4:0] exp_f;                           // exponent field
      logic [8:0] base_f;                          // base mantissa field
      logic [7:0] tl_f;                            // top or length field
   } ccbc_fields_type;

   typedef struct packed {
      logic [31:0] base;                           // requested base
      logic [31:0] length;                         // requested length
   } ccbc_enc_in_type;

   typedef struct packed {
      logic [4:0] exp_f;                           // encoded exponent field
      logic [8:0] base_f;                          // encoded base field
      logic [7:0] top_f;                           // top field, top variant
      logic [7:0] len_f;                           // length field, length variant
   } ccbc_enc_out_type;

   typedef struct packed {
      ccbc_fmt_type    fmt;                        // which stored variant
      ccbc_fields_type fields;                     // stored bounds fields
      logic [31:0]     addr;                       // capability address
      logic            tag;                        // incoming tag
   } ccbc_dec_in_type;

   typedef struct packed {
      logic [31:0] base;                           // decoded base
      logic [32:0] top;                            // decoded top
      logic [4:0]  exp;                            // decoded exponent
      logic        rsv;                            // reserved exponent seen
      logic        rep_ok;                         // address representable
      logic        tag;                            // tag after checks
   } ccbc_dec_out_type;

   localparam ccbc_enc_out_type ENC_OUT_RST = '0;  // encoder output at reset
   localparam ccbc_dec_out_type DEC_OUT_RST = '0;  // decoder output at reset

endpackage

/* File: verif/ccbc_dp_model.sv */
// request-side model of the capability datapath feeding the codec
`timescale 1ns/1ps

module ccbc_dp_model (
   input  wire logic                       mclk,
   output      logic                       enc_req,
   output      ccbc_pkg::ccbc_enc_in_type  enc_in,
   output      logic                       dec_req,
   output      ccbc_pkg::ccbc_dec_in_type  dec_in
);
   import ccbc_pkg::*;

   // quiet start so nothing is requested during reset
   initial begin
      enc_req = 1'b0;
      enc_in  = '0;
      dec_req = 1'b0;
      dec_in  = '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one cycle of requests, launched just after the edge; an idle operand is
   // inverted so a codec that samples it without its request gets caught
   task automatic put(input logic e, input ccbc_enc_in_type ev, input logic d, input ccbc_dec_in_type dv);
      @(posedge mclk);
      enc_req <= e;
      enc_in  <= e ? ev : ccbc_enc_in_type'(~enc_in);
      dec_req <= d;
      dec_in  <= d ? dv : ccbc_dec_in_type'(~dec_in);
   endtask
endmodule

/* File: verif/compressed_capability_bounds_codec_bench.sv */
// self-checking bench for the capability bounds codec
`timescale 1ns/1ps

module compressed_capability_bounds_codec_bench;
   import ccbc_pkg::*;

   logic             mclk;             // 125 MHz clock
   logic             srst;             // synchronous reset
   logic             enc_req;          // from the datapath model
   ccbc_enc_in_type  enc_in;
   logic             dec_req;
   ccbc_dec_in_type  dec_in;
   logic             enc_valid_r;      // codec results
   ccbc_enc_out_type enc_out_r;
   logic             dec_valid_r;
   ccbc_dec_out_type dec_out_r;
   int               mismatches;
   int               samples_checked;

   ccbc_top uut (.mclk(mclk), .srst(srst), .enc_req(enc_req), .enc_in(enc_in), .enc_valid_r(enc_valid_r),
      .enc_out_r(enc_out_r), .dec_req(dec_req), .dec_in(dec_in), .dec_valid_r(dec_valid_r), .dec_out_r(dec_out_r));
   ccbc_dp_model dp (.mclk(mclk), .enc_req(enc_req), .enc_in(enc_in), .dec_req(dec_req), .dec_in(dec_in));

   // free-running clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // comparison and closing report
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] expv);
      samples_checked++;
      if (seen !== expv) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, expv, seen);
      end
   endtask

   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // reference encoder, straight from the bounds algorithm
   function automatic ccbc_enc_out_type ref_enc(input logic [31:0] b, input logic [31:0] l);
      ccbc_enc_out_type r;
      int               e;
      logic [32:0]      b33;
      logic [32:0]      t33;
      logic [9:0]       bs;
      logic [9:0]       ts;
      logic [8:0]       d;
      e = 0;
      for (int i = 9; i < 32; i++) begin
         if (l[i]) e = i - 8;
      end
      b33 = {1'b0, b};
      t33 = b33 + {1'b0, l};
      // second pass only when the rounded slice overflowed
      for (int k = 0; k < 2; k++) begin
         bs = 10'(b33 >> e);
         ts = 10'(t33 >> e) + 10'((t33 & ((33'h1 << e) - 33'h1)) != 33'h0);
         if (k == 0 && (ts - bs) >= 10'h200) e = e + 1;
         else break;
      end
      d = ts[8:0] - bs[8:0];
      r.exp_f  = (e == 0 && !d[8]) ? 5'h1F : 5'(e);
      r.base_f = bs[8:0];
      r.top_f  = ts[7:0];
      r.len_f  = d[7:0];
      return r;
   endfunction

   // reference decoder; 33-bit math keeps the top carry
   function automatic ccbc_dec_out_type ref_dec(input ccbc_dec_in_type di);
      ccbc_dec_out_type r;
      logic [4:0]       ex;
      int               e;
      logic [8:0]       bf;
      logic [8:0]       tf;
      logic             ah;
      logic             th;
      logic [32:0]      a33;
      logic [32:0]      hi;
      ex = di.fields.exp_f;
      e  = (ex == 5'h1F) ? 0 : int'(ex);
      bf = di.fields.base_f;
      tf = {bf[8] ^ (ex != 5'h1F) ^ (di.fields.tl_f < bf[7:0]), di.fields.tl_f};
      a33 = {1'b0, di.addr};
      ah = 9'(a33 >> e) < bf;
      th = tf < bf;
      hi = a33 >> (e + 9);
      r.base = 32'(((hi - 33'(ah)) << (e + 9)) | (33'(bf) << e));
      if (di.fmt == CCBC_FMT_TOP) r.top = ((hi - 33'(ah) + 33'(th)) << (e + 9)) | (33'(tf) << e);
      else r.top = {1'b0, r.base} + (33'({ex != 5'h1F, di.fields.tl_f}) << e);
      r.exp    = 5'(e);
      r.rsv    = (ex > 5'h18) && (ex != 5'h1F);
      r.rep_ok = ({1'b0, r.base} <= a33) && ({1'b0, a33} < {2'b00, r.base} + (34'h1 << (e + 9)));
      r.tag    = di.tag & r.rep_ok & !r.rsv;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // back-to-back decodes; reserved codes only define rsv and tag
   task automatic dec_batch(input ccbc_dec_in_type q[$]);
      ccbc_dec_out_type x;
      for (int i = 0; i <= q.size(); i++) begin
         if (i < q.size()) dp.put(1'b0, '0, 1'b1, q[i]);
         else dp.put(1'b0, '0, 1'b0, '0);
         #1;
         if (i > 0) begin
            x = ref_dec(q[i-1]);
            check("dec_valid", dec_valid_r, 1'b1);
            if (x.rsv) check("dec_rsv_tag", {dec_out_r.rsv, dec_out_r.tag}, 2'b10);
            else check("dec_out", dec_out_r, x);
         end
      end
      dp.put(1'b0, '0, 1'b0, '0);
      #1;
      check("dec_idle", {dec_valid_r, dec_out_r.rsv, dec_out_r.tag}, {1'b0, x.rsv, x.tag});
   endtask

   // encodes of edge lengths, then both stored variants decoded
   task automatic t_encode();
      ccbc_enc_in_type  q[$];
      ccbc_dec_in_type  rt[$];
      ccbc_enc_out_type x;
      q = '{'{32'h0000_1000, 32'h0000_0000}, '{32'h0000_0003, 32'h0000_00FF}, '{32'h0000_0001, 32'h0000_0100},
         '{32'h0000_0001, 32'h0000_01FF}, '{32'h0000_0003, 32'h0000_03FF}, '{32'h1234_5678, 32'h0001_0000},
         '{32'h0000_0000, 32'hFFFF_FFFF}, '{32'h8000_0000, 32'h8000_0000}, '{32'h0000_03F0, 32'h0000_0020}};
      for (int i = 0; i <= q.size(); i++) begin
         if (i < q.size()) dp.put(1'b1, q[i], 1'b0, '0);
         else dp.put(1'b0, '0, 1'b0, '0);
         #1;
         if (i > 0) begin
            x = ref_enc(q[i-1].base, q[i-1].length);
            check("enc_valid", enc_valid_r, 1'b1);
            check("enc_out", enc_out_r, x);
            check("enc_code", (enc_out_r.exp_f <= 5'h18) || (enc_out_r.exp_f == 5'h1F), 1'b1);
            rt.push_back('{CCBC_FMT_TOP, '{x.exp_f, x.base_f, x.top_f}, q[i-1].base, 1'b1});
            rt.push_back('{CCBC_FMT_LEN, '{x.exp_f, x.base_f, x.len_f}, q[i-1].base, 1'b1});
         end
      end
      dp.put(1'b0, '0, 1'b0, '0);
      #1;
      check("enc_idle", {enc_valid_r, enc_out_r}, {1'b0, x});
      dec_batch(rt);
   endtask

   // corrections, out-of-region address, tag off, reserved codes
   task automatic t_decode();
      ccbc_dec_in_type q[$];
      q = '{'{CCBC_FMT_TOP, '{5'h00, 9'h1F0, 8'h10}, 32'h0000_0205, 1'b1},
         '{CCBC_FMT_TOP, '{5'h18, 9'h001, 8'h80}, 32'h0000_0000, 1'b1},
         '{CCBC_FMT_LEN, '{5'h18, 9'h001, 8'h80}, 32'h0000_0000, 1'b1},
         '{CCBC_FMT_LEN, '{5'h1F, 9'h010, 8'h20}, 32'h0000_0015, 1'b1},
         '{CCBC_FMT_TOP, '{5'h00, 9'h0F0, 8'hF0}, 32'h0000_0205, 1'b1},
         '{CCBC_FMT_LEN, '{5'h00, 9'h0F0, 8'h00}, 32'h0000_0205, 1'b1},
         '{CCBC_FMT_TOP, '{5'h05, 9'h0A3, 8'h40}, 32'h0001_4A60, 1'b0}};
      for (int c = 25; c <= 30; c++) begin
         q.push_back('{ccbc_fmt_type'(c[0]), '{5'(c), 9'h0C0, 8'h40}, 32'h0000_0000, 1'b1});
      end
      dec_batch(q);
   endtask

   // reset lands on the edge that would take both requests
   task automatic t_reset_mid();
      dp.put(1'b1, '{32'h0000_0040, 32'h0000_0300}, 1'b1, '{CCBC_FMT_TOP, '{5'h02, 9'h010, 8'h80}, 32'h40, 1'b1});
      srst <= 1'b1;
      dp.put(1'b0, '0, 1'b0, '0);
      #1;
      check("rst_outs", {enc_valid_r, dec_valid_r, enc_out_r, dec_out_r}, '0);
      @(posedge mclk);
      srst <= 1'b0;
      // first request after the release must be taken normally
      dp.put(1'b1, '{32'h0000_0003, 32'h0000_00FF}, 1'b0, '0);
      dp.put(1'b0, '0, 1'b0, '0);
      #1;
      check("rst_resume", {enc_valid_r, enc_out_r}, {1'b1, ref_enc(32'h0000_0003, 32'h0000_00FF)});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      mismatches      = 0;
      samples_checked = 0;
      srst            = 1'b1;
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      #1;
      check("reset_outs", {enc_valid_r, dec_valid_r, enc_out_r, dec_out_r}, '0);
      t_encode();
      t_decode();
      t_reset_mid();
      complete_run();
   end

   // hang guard: a stuck run counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      complete_run();
   end
endmodule
